// *** logic/sfs_ctl.sv ***
// Controller end: non-burst single-word access over the memory pins
module sfs_ctl
  import sfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  sfs_if.ctl bus,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [SFS_ADDR_W-1:0] req_addr_i,
  input wire logic [SFS_LANES-1:0] req_lanes_i,
  input wire logic [SFS_DATA_W-1:0] req_wdata_i,
  input wire logic order_i,
  output logic [SFS_DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic wdone_o
);
  sfs_ctl_e state;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= SFS_ST_IDLE;
      bus.addr <= '0;
      bus.byte_lane_write_n <= SFS_STROBES_IDLE_N;
      bus.byte_write_qualifier_n <= 1'b1;
      bus.global_write_all_n <= 1'b1;
      bus.output_drive_n <= 1'b1;
      bus.ctl_data_out <= '0;
      bus.ctl_data_oe <= 1'b0;
      bus.burst_order_select <= order_i;
    end
    else if (ce_i)
    begin
      bus.burst_order_select <= order_i;
      case (state)
        SFS_ST_IDLE,
        SFS_ST_READ,
        SFS_ST_WRITE:
        begin
          bus.byte_lane_write_n <= SFS_STROBES_IDLE_N;
          bus.byte_write_qualifier_n <= 1'b1;
          bus.ctl_data_oe <= 1'b0;
          // Drive enable low while the memory shows the read word
          bus.output_drive_n <= (state != SFS_ST_READ);
          state <= SFS_ST_IDLE;
          if (req_i)
          begin
            bus.addr <= req_addr_i;
            if (req_write_i)
            begin
              bus.byte_lane_write_n <= ~req_lanes_i;
              bus.byte_write_qualifier_n <= 1'b0;
              bus.ctl_data_out <= req_wdata_i;
              bus.ctl_data_oe <= 1'b1;
              // A write right behind a read blanks that read's word on the lanes
              bus.output_drive_n <= 1'b1;
              state <= SFS_ST_WRITE;
            end
            else
            begin
              state <= SFS_ST_READ;
            end
          end
        end
        default:
          state <= SFS_ST_IDLE;
      endcase
    end
  end
  // Non-burst tie-offs; other enables held at their active levels
  always_comb
  begin
    bus.cpu_address_strobe_n = 1'b1;
    bus.ctrl_address_strobe_n = 1'b0;
    bus.burst_step_n = 1'b1;
    bus.primary_enable_n = 1'b0;
    bus.depth_enable_high = 1'b1;
    bus.depth_enable_low_n = 1'b0;
  end
  // Lanes come from the memory one cycle after the address pins, so rd_d1 delays the read flag one stage before capture
  logic rd_d1;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_d1 <= 1'b0;
      rvalid_o <= 1'b0;
      wdone_o <= 1'b0;
      rdata_o <= '0;
    end
    else if (ce_i)
    begin
      // Flow-through word stands in the cycle after the address pins
      rd_d1 <= (state == SFS_ST_READ);
      rvalid_o <= rd_d1;
      if (rd_d1)
        rdata_o <= bus.data_lanes;
      wdone_o <= (state == SFS_ST_WRITE);
    end
  end
  logic unused_ok;
  assign unused_ok = bus.mem_data_oe;
endmodule

// *** logic/sfs_if.sv ***
// Pin-level connection between the memory and its controller
interface sfs_if;
  import sfs_pkg::*;
  logic [SFS_ADDR_W-1:0] addr;
  logic [SFS_LANES-1:0] byte_lane_write_n;
  logic byte_write_qualifier_n;
  logic global_write_all_n;
  logic cpu_address_strobe_n;
  logic ctrl_address_strobe_n;
  logic burst_step_n;
  logic primary_enable_n;
  logic depth_enable_high;
  logic depth_enable_low_n;
  logic burst_order_select;
  logic output_drive_n;
  logic [SFS_DATA_W-1:0] mem_data_out;
  logic mem_data_oe;
  logic [SFS_DATA_W-1:0] ctl_data_out;
  logic ctl_data_oe;
  logic [SFS_DATA_W-1:0] data_lanes;
  assign data_lanes = mem_data_oe ? mem_data_out : ctl_data_out;
  modport mem
  (
    input addr, byte_lane_write_n, byte_write_qualifier_n, global_write_all_n,
    input cpu_address_strobe_n, ctrl_address_strobe_n, burst_step_n,
    input primary_enable_n, depth_enable_high, depth_enable_low_n,
    input burst_order_select, output_drive_n, ctl_data_out, ctl_data_oe,
    output mem_data_out, mem_data_oe
  );
  modport ctl
  (
    output addr, byte_lane_write_n, byte_write_qualifier_n, global_write_all_n,
    output cpu_address_strobe_n, ctrl_address_strobe_n, burst_step_n,
    output primary_enable_n, depth_enable_high, depth_enable_low_n,
    output burst_order_select, output_drive_n, ctl_data_out, ctl_data_oe,
    input mem_data_out, mem_data_oe, data_lanes
  );
endinterface

// *** logic/sfs_mem.sv ***
// Memory end: registered controls, burst counter, byte writes, flow-through read
// Function
// - Write when qualifier plus lane, or global write
// - Enabled: primary low, depth high, depth low
// - Never drive lanes during a write cycle
// - Controller releases drive enable before writes
// - Non-burst tie-offs give new address each cycle
// - Burst order held fixed, never floating
// - Emulation ties only listed pins; others operate
// - Read data flows through without output register
// - Burst order unregistered; low linear, high interleaved
// - Burst step advances 2-bit counter in order
// - CPU strobe with primary high is blocked
// - Write selected lanes, or all on global
module sfs_mem
  import sfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  sfs_if.mem bus,
  output logic selected_o,
  output logic writing_o
);

  logic [SFS_ADDR_W-1:0] base_addr;
  logic [1:0] burst_cnt;
  logic active;
  logic wr_cyc;
  logic [SFS_LANES-1:0] lane_wr;
  logic [SFS_DATA_W-1:0] rd_word;
  logic [SFS_ADDR_W-1:0] rd_addr;
  logic [SFS_ADDR_W-1:0] wr_addr;
  logic eff_active;
  logic eff_write;

  // Registered pins
  logic [SFS_ADDR_W-1:0] r_addr;
  logic [SFS_LANES-1:0] r_lane_n;
  logic r_qual_n;
  logic r_glob_n;
  logic r_cpu_strobe_n;
  logic r_ctrl_strobe_n;
  logic r_step_n;
  logic r_pe_n;
  logic r_deh;
  logic r_del_n;
  logic [SFS_DATA_W-1:0] r_din;

  // Decoded from the registered pins; next_cnt and cur_addr from the counter and the live burst order pin
  logic next_enabled;
  logic next_start;
  logic next_deselect;
  logic next_write;
  logic [SFS_LANES-1:0] next_lanes;
  logic [1:0] next_cnt;
  logic [SFS_ADDR_W-1:0] cur_addr;

  // Address and write data are taken on every enabled edge
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      r_addr <= bus.addr;
      r_din <= bus.ctl_data_out;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      r_lane_n <= bus.byte_lane_write_n;
      r_qual_n <= bus.byte_write_qualifier_n;
      r_glob_n <= bus.global_write_all_n;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      r_cpu_strobe_n <= bus.cpu_address_strobe_n;
      r_ctrl_strobe_n <= bus.ctrl_address_strobe_n;
      r_step_n <= bus.burst_step_n;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      r_pe_n <= bus.primary_enable_n;
      r_deh <= bus.depth_enable_high;
      r_del_n <= bus.depth_enable_low_n;
    end
  end

  always_comb
  begin
    next_enabled = !r_pe_n && r_deh && !r_del_n;
    // CPU strobe only counts with primary enable low
    next_start = (!r_cpu_strobe_n && !r_pe_n) || !r_ctrl_strobe_n;
    next_deselect = next_start && !next_enabled;
  end

  always_comb
  begin
    next_write = (!r_qual_n && (r_lane_n != SFS_STROBES_IDLE_N)) || !r_glob_n;
    next_lanes = !r_glob_n ? SFS_LANES_ALL
      : (!r_qual_n ? ~r_lane_n : SFS_LANES_NONE);
  end

  // Burst order is live: never registered, so a change mid-burst reorders at once
  always_comb
  begin
    if (bus.burst_order_select == SFS_ORDER_INTERLEAVED)
      next_cnt = base_addr[1:0] ^ burst_cnt;
    else
      next_cnt = 2'(base_addr[1:0] + burst_cnt);
    cur_addr = {base_addr[SFS_ADDR_W-1:2], next_cnt};
  end

  // Counter is plain binary; only the low address bits depend on the order
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active <= 1'b0;
    end
    else if (ce_i && next_start)
    begin
      active <= next_enabled;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base_addr <= '0;
      burst_cnt <= 2'h0;
    end
    else if (ce_i)
    begin
      if (next_start)
      begin
        base_addr <= r_addr;
        burst_cnt <= 2'h0;
      end
      else if (active && !r_step_n)
        burst_cnt <= 2'(burst_cnt + SFS_BURST_ONE);
    end
  end

  // Writes land on the address in effect when strobes were sampled
  assign wr_addr = next_start ? r_addr : cur_addr;
  assign eff_active = next_start ? next_enabled : active;
  assign eff_write = eff_active && next_write;
  assign wr_cyc = active && next_write && !next_deselect;
  assign lane_wr = wr_cyc ? next_lanes : SFS_LANES_NONE;
  assign rd_addr = eff_active ? wr_addr : cur_addr;

  // One array per lane, so each lane has a single writing process
  genvar g;
  generate
    for (g = 0; g < SFS_LANES; g = g + 1)
    begin : g_lane
      logic [SFS_LANE_W-1:0] lane_mem [SFS_DEPTH];
      always_ff @(posedge clk_i)
      begin
        if (ce_i && eff_write && next_lanes[g])
          lane_mem[wr_addr] <= r_din[g*SFS_LANE_W +: SFS_LANE_W];
      end
      // Flow-through: array read straight to pins, no output stage
      assign rd_word[g*SFS_LANE_W +: SFS_LANE_W] = lane_mem[rd_addr];
    end
  endgenerate

  always_comb
  begin
    bus.mem_data_out = rd_word;
    // Output drive enable ignored while a write is in progress
    bus.mem_data_oe = eff_active && !eff_write && !bus.output_drive_n;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      selected_o <= 1'b0;
    end
    else if (ce_i)
    begin
      selected_o <= eff_active;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      writing_o <= 1'b0;
    end
    else if (ce_i)
    begin
      writing_o <= eff_write;
    end
  end

  logic unused_ok;
  assign unused_ok = wr_cyc ^ (|lane_wr) ^ next_deselect;
endmodule

// *** logic/sfs_pkg.sv ***
// Shared constants and types for the flow-through burst memory and its controller
package sfs_pkg;
  localparam int SFS_ADDR_W = 15;
  localparam int SFS_LANES = 4;
  localparam int SFS_LANE_W = 9;
  localparam int SFS_DATA_W = SFS_LANES * SFS_LANE_W;
  localparam int SFS_DEPTH = 32768;
  localparam logic [1:0] SFS_BURST_ONE = 2'h1;
  localparam logic SFS_ORDER_LINEAR = 1'b0;
  localparam logic SFS_ORDER_INTERLEAVED = 1'b1;
  localparam logic [SFS_LANES-1:0] SFS_LANES_NONE = 4'h0;
  localparam logic [SFS_LANES-1:0] SFS_LANES_ALL = 4'hF;
  localparam logic [SFS_LANES-1:0] SFS_STROBES_IDLE_N = 4'hF;
  typedef enum logic [2:0]
  {
    SFS_ST_IDLE = 3'b001,
    SFS_ST_READ = 3'b010,
    SFS_ST_WRITE = 3'b100
  } sfs_ctl_e;
endpackage

// *** verification/sfs_assertions.sv ***
// Pin-level checks on the memory and controller interface
module sfs_assertions
  import sfs_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic [SFS_LANES-1:0] byte_lane_write_n,
  input logic byte_write_qualifier_n,
  input logic global_write_all_n,
  input logic cpu_address_strobe_n,
  input logic ctrl_address_strobe_n,
  input logic burst_step_n,
  input logic primary_enable_n,
  input logic depth_enable_high,
  input logic depth_enable_low_n,
  input logic burst_order_select,
  input logic output_drive_n,
  input logic mem_data_oe,
  input logic ctl_data_oe,
  input logic selected_o,
  input logic writing_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en;
  logic wr;
  assign en = !primary_enable_n && depth_enable_high && !depth_enable_low_n;
  assign wr = (!byte_write_qualifier_n && |(~byte_lane_write_n)) || !global_write_all_n;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    !ctrl_address_strobe_n && en;
  endsequence
  a_write_decode: assert property (s_take |-> ##2 (writing_o == $past(wr, 2)))
    else $error("write decode wrong");
  a_enable_decode: assert property (!ctrl_address_strobe_n |-> ##2 (selected_o == $past(en, 2)))
    else $error("enable decode wrong");
  a_no_drive_write: assert property (s_take ##0 wr |=> !mem_data_oe)
    else $error("memory drove during write");
  a_no_contention: assert property (!(mem_data_oe && ctl_data_oe))
    else $error("both ends drive lanes");
  a_drive_off_write: assert property (wr |-> output_drive_n)
    else $error("drive enable on at write");
  a_nonburst_ties: assert property (cpu_address_strobe_n && burst_step_n)
    else $error("non-burst ties broken");
  a_order_steady: assert property (!$past(rst_i) |-> $stable(burst_order_select))
    else $error("burst order moved");
  // Drive enable is asynchronous, so read data must follow it in the same cycle
  a_flow_read: assert property (s_take ##0 !wr |=> mem_data_oe == !output_drive_n)
    else $error("read data not flowing");
endmodule

// *** verification/sync_flowthrough_sram_control_tb.sv ***
// Bench joining memory and controller ends with a shadow store
module sync_flowthrough_sram_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sfs_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic req_i = 1'h0;
  logic req_write_i = 1'h0;
  logic [SFS_ADDR_W-1:0] req_addr_i = '0;
  logic [SFS_LANES-1:0] req_lanes_i = '0;
  logic [SFS_DATA_W-1:0] req_wdata_i = '0;
  logic order_i = SFS_ORDER_LINEAR;
  logic [SFS_DATA_W-1:0] rdata_o;
  logic rvalid_o;
  logic wdone_o;
  logic selected_o;
  logic writing_o;
  logic [SFS_DATA_W:0] note_q[$];
  logic [SFS_DATA_W-1:0] shadow[int];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  sfs_if b();
  sfs_mem i_sfs_mem(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .bus(b),
    .selected_o(selected_o), .writing_o(writing_o));
  sfs_ctl i_sfs_ctl(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .bus(b), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_lanes_i(req_lanes_i),
    .req_wdata_i(req_wdata_i), .order_i(order_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .wdone_o(wdone_o));
  sfs_assertions i_sfs_assertions(.clk_i(clk_i), .rst_i(rst_i),
    .byte_lane_write_n(b.byte_lane_write_n), .byte_write_qualifier_n(b.byte_write_qualifier_n),
    .global_write_all_n(b.global_write_all_n), .cpu_address_strobe_n(b.cpu_address_strobe_n),
    .ctrl_address_strobe_n(b.ctrl_address_strobe_n), .burst_step_n(b.burst_step_n),
    .primary_enable_n(b.primary_enable_n), .depth_enable_high(b.depth_enable_high),
    .depth_enable_low_n(b.depth_enable_low_n), .burst_order_select(b.burst_order_select),
    .output_drive_n(b.output_drive_n), .mem_data_oe(b.mem_data_oe),
    .ctl_data_oe(b.ctl_data_oe), .selected_o(selected_o), .writing_o(writing_o));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic check(input logic [SFS_DATA_W:0] seen, input logic [SFS_DATA_W:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    // An answer that never came leaves its note behind
    if (note_q.size() != 0)
      failures++;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Notes hold a write flag on top of the expected read word
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
    if (rvalid_o === 1'h1 || wdone_o === 1'h1)
      check({wdone_o, wdone_o ? SFS_DATA_W'(0) : rdata_o}, note_q.size() ? note_q.pop_front() : 'x);
  end
  // Request fields settle a few cycles ahead of the one-cycle request pulse
  task automatic op(input logic w, input logic [SFS_ADDR_W-1:0] a,
    input logic [SFS_LANES-1:0] l, input logic [SFS_DATA_W-1:0] d);
    int k;
    req_write_i <= w;
    req_addr_i <= a;
    req_lanes_i <= l;
    req_wdata_i <= d;
    repeat (3) @(posedge clk_i);
    if (w)
    begin
      for (k = 0; k < SFS_LANES; k++)
        if (l[k])
          shadow[a][SFS_LANE_W*k +: SFS_LANE_W] = d[SFS_LANE_W*k +: SFS_LANE_W];
      note_q.push_back({1'h1, SFS_DATA_W'(0)});
    end
    else
      note_q.push_back({1'h0, shadow[a]});
    req_i <= 1'h1;
    @(posedge clk_i);
    req_i <= 1'h0;
    for (k = 0; k < 12 && note_q.size() > 0; k++)
      @(posedge clk_i);
  endtask
  initial
  begin
    void'($urandom(44));
    for (int p = 0; p < 2; p++)
    begin
      rst_i <= 1'h1;
      order_i <= p[0];
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      // Edge addresses at both ends of the array
      for (int a = 0; a < 4; a++)
        op(1'h1, SFS_ADDR_W'(a - 2), SFS_LANES_ALL, SFS_DATA_W'({$urandom, $urandom}));
      for (int i = 0; i < 60; i++)
        op(1'($urandom), SFS_ADDR_W'(($urandom % 4) - 2), SFS_LANES'($urandom),
          SFS_DATA_W'({$urandom, $urandom}));
    end
    finish_test();
  end
endmodule
